// ===== position_packet_framer.sv
// Periodic binary position report framer with APB registers
//
// What this block does
// - Transmit only; there is no receive path at all.
// - Report starts every period, default 100 ms, software can change it.
// - Timing comes from the period counter alone, not position arrival.
// - Locked-only set: send only when lock level is 2, else skip.
// - Locked-only clear: send every period, zero coordinates when unlocked.
// - Multi-byte integers go out most significant byte first.
// - Every field is whole bytes, bit field or integer.
// - One configuration gives fixed packet length and layout.
// - Nothing sent before link opens; first byte sent opens a packet.
// - Packet opens with unescaped 0x7E.
// - Packet closes with unescaped 0x7F as final byte.
// - Stuffing turns 0x7D/0x7E/0x7F content into 0x7D, byte XOR 0x20.
// - Stuffing on after reset; a control bit can disable it.
// - Optional fields in fixed order: timestamp then position.
// - Start and end fields are always present.
// - Two-byte unsigned total length follows opening byte, counting all.
// - Four-byte field select mask follows; start field is 7 bytes.
// - Timestamp is 4-byte seconds then 2-byte milliseconds.
// - Seconds and milliseconds clock restarts at zero on reset.
// - Position is signed 4-byte x, y in mm, then 1-byte lock.
// - Lock level 0 or 1 unreliable, 2 reliable.
`timescale 1ns/1ps
`default_nettype none

module position_packet_framer #(
  parameter int CYCLES_PER_MS = framer_pkg::CYCLES_PER_MS,
  parameter int ADDR_W = 8
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic link_open,
  input wire logic [31:0] pos_x,
  input wire logic [31:0] pos_y,
  input wire logic [7:0] position_lock_level,
  output logic tx_valid,
  output logic [7:0] tx_data,
  input wire logic tx_ready
);
  import framer_pkg::*;

  typedef struct packed {
    frame_state_t st;
    logic [31:0] div;
    logic [15:0] per;
    logic [31:0] stamp_seconds;
    logic [9:0] stamp_millis;
    logic [MAX_BYTES-1:0][7:0] pkt;
    logic [7:0] len;
    logic [7:0] idx;
    logic esc;
    logic tx_valid;
    logic [7:0] tx_data;
    logic [CTRL_W-1:0] ctrl;
    logic [15:0] report_period_ms;
    logic [15:0] sent;
    logic [15:0] skipped;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } framer_regs_t;

  framer_regs_t state_reg;
  framer_regs_t state_next;

  localparam framer_regs_t RESET_VAL = '{
    st: IDLE,
    div: '0,
    per: '0,
    stamp_seconds: '0,
    stamp_millis: '0,
    pkt: '0,
    len: '0,
    idx: '0,
    esc: 1'b0,
    tx_valid: 1'b0,
    tx_data: '0,
    ctrl: CTRL_RESET,
    report_period_ms: PERIOD_DEFAULT_MS,
    sent: '0,
    skipped: '0,
    pready: 1'b0,
    pslverr: 1'b0,
    prdata: '0
  };

  // Byte that must be escaped on the wire
  function automatic logic reserved(input logic [7:0] b);
    reserved = (b == BYTE_ESC) || (b == BYTE_OPEN) || (b == BYTE_CLOSE);
  endfunction

  // Byte k of a 32-bit word, most significant first
  function automatic logic [7:0] msb_byte(input logic [31:0] w,
                                          input int k);
    msb_byte = w[31-8*k -: 8];
  endfunction

  logic tick_ms;
  logic tick_per;
  logic locked_ok;
  logic start;
  logic take;
  logic raw;
  logic [7:0] p;
  logic [7:0] b;
  logic [15:0] limit;
  logic [15:0] plen;
  logic [31:0] mask;
  logic [31:0] x_out;
  logic [31:0] y_out;
  logic [31:0] rd;
  logic bad;
  logic access;
  logic stamp_on;
  logic pos_on;

  always_comb begin
    state_next = state_reg;
    tick_ms = 1'b0;
    tick_per = 1'b0;
    p = '0;
    b = '0;
    raw = 1'b0;
    rd = '0;
    bad = 1'b0;
    stamp_on = state_reg.ctrl[CTRL_STAMP_BIT];
    pos_on = state_reg.ctrl[CTRL_POS_BIT];

    // Millisecond time base
    if (state_reg.div >= 32'(CYCLES_PER_MS - 1)) begin
      state_next.div = '0;
      tick_ms = 1'b1;
    end else begin
      state_next.div = state_reg.div + 32'h1;
    end

    if (tick_ms) begin
      if (state_reg.stamp_millis == MS_PER_S - 10'd1) begin
        state_next.stamp_millis = '0;
        state_next.stamp_seconds = state_reg.stamp_seconds + 32'h1;
      end else begin
        state_next.stamp_millis = state_reg.stamp_millis + 10'd1;
      end
    end

    limit = (state_reg.report_period_ms == '0) ? 16'h1 :
            state_reg.report_period_ms;
    if (tick_ms) begin
      if (state_reg.per >= limit - 16'h1) begin
        state_next.per = '0;
        tick_per = 1'b1;
      end else begin
        state_next.per = state_reg.per + 16'h1;
      end
    end

    locked_ok = !state_reg.ctrl[CTRL_LOCKED_BIT] ||
                (position_lock_level == LOCK_RELIABLE);
    start = tick_per && state_reg.ctrl[CTRL_EN_BIT] && link_open &&
            locked_ok && (state_reg.st == IDLE);
    if (tick_per && !start) begin
      state_next.skipped = state_reg.skipped + 16'h1;
    end

    take = !state_reg.tx_valid || tx_ready;
    if (take) begin
      state_next.tx_valid = 1'b0;
    end
    if (take && state_reg.st == SEND) begin
      if (state_reg.idx == state_reg.len) begin
        state_next.st = IDLE;
        state_next.sent = state_reg.sent + 16'h1;
      end else begin
        b = state_reg.pkt[state_reg.idx];
        raw = (state_reg.idx == '0) ||
              (state_reg.idx == state_reg.len - 8'h1);
        state_next.tx_valid = 1'b1;
        if (!raw && !state_reg.ctrl[CTRL_NOSTUFF_BIT] && reserved(b)) begin
          if (!state_reg.esc) begin
            state_next.tx_data = BYTE_ESC;
            state_next.esc = 1'b1;
          end else begin
            state_next.tx_data = b ^ ESC_XOR;
            state_next.esc = 1'b0;
            state_next.idx = state_reg.idx + 8'h1;
          end
        end else begin
          state_next.tx_data = b;
          state_next.idx = state_reg.idx + 8'h1;
        end
      end
    end

    plen = START_LEN + END_LEN + (stamp_on ? STAMP_LEN : 16'h0) +
           (pos_on ? POS_LEN : 16'h0);
    mask = '0;
    mask[MASK_STAMP_BIT] = stamp_on;
    mask[MASK_POS_BIT] = pos_on;
    x_out = (position_lock_level == LOCK_RELIABLE) ? pos_x : '0;
    y_out = (position_lock_level == LOCK_RELIABLE) ? pos_y : '0;

    if (start) begin
      state_next.pkt = '0;
      state_next.pkt[0] = BYTE_OPEN;
      state_next.pkt[1] = plen[15:8];
      state_next.pkt[2] = plen[7:0];
      for (int k = 0; k < 4; k++) begin
        state_next.pkt[3+k] = msb_byte(mask, k);
      end
      p = START_LEN[7:0];
      if (stamp_on) begin
        for (int k = 0; k < 4; k++) begin
          state_next.pkt[p] = msb_byte(state_reg.stamp_seconds, k);
          p = p + 8'h1;
        end
        state_next.pkt[p] = {6'h0, state_reg.stamp_millis[9:8]};
        state_next.pkt[p+8'h1] = state_reg.stamp_millis[7:0];
        p = p + 8'h2;
      end
      if (pos_on) begin
        for (int k = 0; k < 4; k++) begin
          state_next.pkt[p] = msb_byte(x_out, k);
          state_next.pkt[p+8'h4] = msb_byte(y_out, k);
          p = p + 8'h1;
        end
        p = p + 8'h4;
        state_next.pkt[p] = position_lock_level;
        p = p + 8'h1;
      end
      state_next.pkt[p] = BYTE_CLOSE;
      state_next.len = plen[7:0];
      state_next.idx = '0;
      state_next.esc = 1'b0;
      state_next.st = SEND;
    end

    // APB slave: answer one cycle into access phase
    access = psel && penable;
    state_next.pready = 1'b0;
    state_next.pslverr = 1'b0;
    unique case (paddr)
      ADDR_W'(CTRL_OFS): rd = {{(32-CTRL_W){1'b0}}, state_reg.ctrl};
      ADDR_W'(PERIOD_OFS): rd = {16'h0, state_reg.report_period_ms};
      ADDR_W'(STATUS_OFS): begin
        rd[STAT_BUSY_BIT] = (state_reg.st == SEND);
        rd[STAT_LINK_BIT] = link_open;
        rd[STAT_LEN_LSB +: 16] = plen;
      end
      ADDR_W'(STAMP_OFS): rd = state_reg.stamp_seconds;
      ADDR_W'(COUNT_OFS): rd = {state_reg.skipped, state_reg.sent};
      default: bad = 1'b1;
    endcase
    if (access && !state_reg.pready) begin
      state_next.pready = 1'b1;
      state_next.pslverr = bad;
      state_next.prdata = (bad || pwrite) ? 32'h0 : rd;
    end
    // Write commits on the completing edge
    if (access && state_reg.pready && pwrite && !state_reg.pslverr) begin
      if (paddr == ADDR_W'(CTRL_OFS)) begin
        state_next.ctrl = pwdata[CTRL_W-1:0];
      end
      if (paddr == ADDR_W'(PERIOD_OFS)) begin
        state_next.report_period_ms = pwdata[15:0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      state_reg <= RESET_VAL;
    end else if (ce) begin
      state_reg <= state_next;
    end
  end

  assign tx_valid = state_reg.tx_valid;
  assign tx_data = state_reg.tx_data;
  assign prdata = state_reg.prdata;
  assign pready = state_reg.pready;
  assign pslverr = state_reg.pslverr;

endmodule // position_packet_framer

`default_nettype wire

// ===== framer_pkg.sv
// Shared constants for the position report framer
package framer_pkg;

  // Clock and time base
  localparam int CLK_PERIOD_NS = 5;
  localparam int NS_PER_MS = 1000000;
  localparam int CYCLES_PER_MS = NS_PER_MS / CLK_PERIOD_NS;
  localparam logic [9:0] MS_PER_S = 10'd1000;
  localparam logic [15:0] PERIOD_DEFAULT_MS = 16'd100;

  // Reserved symbols and stuffing
  localparam logic [7:0] BYTE_OPEN = 8'h7E;
  localparam logic [7:0] BYTE_CLOSE = 8'h7F;
  localparam logic [7:0] BYTE_ESC = 8'h7D;
  localparam logic [7:0] ESC_XOR = 8'h20;

  // Field lengths in bytes
  localparam logic [15:0] START_LEN = 16'd7;
  localparam logic [15:0] END_LEN = 16'd1;
  localparam logic [15:0] STAMP_LEN = 16'd6;
  localparam logic [15:0] POS_LEN = 16'd9;
  localparam int MAX_BYTES = 23;

  // Field select mask bits
  localparam int MASK_STAMP_BIT = 0;
  localparam int MASK_POS_BIT = 1;

  // Lock levels
  localparam logic [7:0] LOCK_RELIABLE = 8'h02;

  // Register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] PERIOD_OFS = 8'h04;
  localparam logic [7:0] STATUS_OFS = 8'h08;
  localparam logic [7:0] STAMP_OFS = 8'h0C;
  localparam logic [7:0] COUNT_OFS = 8'h10;

  // Control register bits
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_LOCKED_BIT = 1;
  localparam int CTRL_NOSTUFF_BIT = 2;
  localparam int CTRL_STAMP_BIT = 3;
  localparam int CTRL_POS_BIT = 4;
  localparam int CTRL_W = 5;
  localparam logic [4:0] CTRL_RESET = 5'h13;

  // Status register bits
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_LINK_BIT = 1;
  localparam int STAT_LEN_LSB = 8;

  typedef enum logic {IDLE, SEND} frame_state_t;

endpackage

// ===== framer_asserts.sv
// Checker for the framer stream and bus handshake
`timescale 1ns/1ps
`default_nettype none
module framer_asserts (
  input wire logic clk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic link_open,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_ready
);
  logic in_pkt, esc_q, acc, fin;
  logic [4:0] cnt;
  logic [15:0] len;
  assign acc = tx_valid && tx_ready;
  assign fin = acc && in_pkt && !esc_q && tx_data == 8'h7F;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // Tracks place within a packet
  always_ff @(posedge clk) begin
    if (!rstn) begin
      in_pkt <= 1'b0;
      esc_q <= 1'b0;
      cnt <= 5'h0;
      len <= 16'h0;
    end else if (acc) begin
      esc_q <= in_pkt && !esc_q && tx_data == 8'h7D;
      if (esc_q || tx_data != 8'h7D) cnt <= in_pkt ? cnt + 5'h1 : 5'h1;
      in_pkt <= !fin;
      if (cnt == 5'h1) len[15:8] <= tx_data;
      if (cnt == 5'h2) len[7:0] <= tx_data;
    end
  end
  property p_hold;
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_data);
  endproperty
  a_hold: assert property (p_hold)
    else $error("byte changed before accept");
  property p_open; tx_valid && !in_pkt |-> tx_data == 8'h7E; endproperty
  a_open: assert property (p_open)
    else $error("packet not opened by 7E");
  property p_close; fin |=> !tx_valid; endproperty
  a_close: assert property (p_close)
    else $error("byte after close");
  property p_esc;
    tx_valid && esc_q |-> tx_data inside {8'h5D, 8'h5E, 8'h5F};
  endproperty
  a_esc: assert property (p_esc)
    else $error("bad escaped byte");
  property p_link;
    !link_open ##1 (!link_open && !in_pkt && !tx_valid) |=> !tx_valid;
  endproperty
  a_link: assert property (p_link)
    else $error("byte sent while link closed");
  property p_len; fin |-> {11'h0, cnt} + 16'h1 == len; endproperty
  a_len: assert property (p_len)
    else $error("length field mismatch");
  property p_mask;
    acc && in_pkt && cnt inside {5'h3, 5'h4, 5'h5} |-> tx_data == 8'h00;
  endproperty
  a_mask: assert property (p_mask)
    else $error("mask upper bytes not zero");
  property p_apb; psel && penable && !pready |=> pready; endproperty
  a_apb: assert property (p_apb)
    else $error("no bus answer");
  c_esc: cover property (acc && esc_q);
  c_fin: cover property (fin);
  c_stall: cover property (tx_valid && !tx_ready);
endmodule // framer_asserts
bind position_packet_framer framer_asserts chk_u (.clk(clk), .rstn(rstn),
  .psel(psel), .penable(penable), .pready(pready), .link_open(link_open),
  .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready));
`default_nettype wire

// ===== rx_model.sv
// Receiver model that takes and unstuffs the byte stream
`timescale 1ns/1ps
`default_nettype none
module rx_model (
  input wire logic clk,
  input wire logic rstn,
  input wire logic stall,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic tx_ready
);
  logic [7:0] dec [0:255];
  logic esc;
  int nd, ps, ne, npk;
  always_ff @(posedge clk) begin
    if (!rstn) begin
      tx_ready <= 1'b0;
      esc <= 1'b0;
      nd <= 0;
      ps <= 0;
      ne <= 0;
      npk <= 0;
    end else begin
      tx_ready <= stall ? !tx_ready : 1'b1;
      if (tx_valid && tx_ready) begin
        if (esc || tx_data != 8'h7D) begin
          dec[nd[7:0]] <= esc ? tx_data ^ 8'h20 : tx_data;
          nd <= nd + 1;
        end
        esc <= !esc && tx_data == 8'h7D;
        if (!esc && tx_data == 8'h7D) ne <= ne + 1;
        if (tx_data == 8'h7E) begin
          ps <= nd;
          ne <= 0;
        end
        if (tx_data == 8'h7F) npk <= npk + 1;
      end
    end
  end
endmodule // rx_model
`default_nettype wire

// ===== test_position_packet_framer.sv
// Self-checking bench for the position report framer
`timescale 1ns/1ps
`default_nettype none
module test_position_packet_framer;
  import framer_pkg::*;
  typedef struct {
    logic lk;
    logic [4:0] c;
    logic [7:0] lock;
    logic [31:0] x, y;
    logic pk, st;
    int e;
  } row_t;
  row_t rows [5] = '{
    '{1'b0, 5'h13, 8'h02, 32'h1, 32'h2, 1'b0, 1'b0, 0},
    '{1'b1, 5'h13, 8'h01, 32'h1, 32'h2, 1'b0, 1'b0, 0},
    '{1'b1, 5'h13, 8'h02, 32'h7D7E7F01, 32'hFFFFFF85, 1'b1, 1'b1, 3},
    '{1'b1, 5'h11, 8'h01, 32'h5, 32'h6, 1'b1, 1'b0, 0},
    '{1'b1, 5'h1B, 8'h02, 32'h01020304, 32'hA0B0C0D0, 1'b1, 1'b0, 0}};
  logic [39:0] regs [6] = '{40'h0000000013, 40'h0400000064,
    40'h0C00000000, 40'h1000000000, 40'h2000000000, 40'h0800001100};
  logic clk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, link_open = 1'b0, stall = 1'b0, ce = 1'b1;
  logic pready, pslverr, tx_valid, tx_ready, err;
  logic [7:0] paddr = 8'h00, lock = 8'h00, tx_data;
  logic [31:0] pwdata = 32'h0, px = 32'h0, py = 32'h0, prdata, rd;
  int num_errors = 0, n_compared = 0, t;
  always #2.5 clk = ~clk;
  position_packet_framer #(.CYCLES_PER_MS(4)) dut_u (.clk(clk),
    .rstn(rstn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .link_open(link_open),
    .pos_x(px), .pos_y(py), .position_lock_level(lock),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready));
  rx_model rx_u (.clk(clk), .rstn(rstn), .stall(stall),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready));
  task automatic close_out();
    $display("compared %0d errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic cmp(string what, logic [31:0] exp, logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic apb(logic wr, logic [7:0] a, logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  function automatic logic [31:0] w32(logic [7:0] i);
    return {rx_u.dec[i], rx_u.dec[i+8'h1], rx_u.dec[i+8'h2], rx_u.dec[i+8'h3]};
  endfunction
  task automatic wait_pk();
    int k;
    k = rx_u.npk;
    t = 0;
    while (rx_u.npk == k && t < 300) begin
      @(posedge clk);
      t++;
    end
  endtask
  task automatic chk(row_t r);
    logic [7:0] n, b;
    logic [31:0] ok;
    n = 8'h8 + (r.c[3] ? 8'h6 : 8'h0) + (r.c[4] ? 8'h9 : 8'h0);
    b = rx_u.ps[7:0];
    ok = r.lock == 8'h02 ? 32'h1 : 32'h0;
    cmp("open", 32'h7E, rx_u.dec[b]);
    cmp("len", {24'h0, n}, w32(b + 8'h1) >> 16);
    cmp("mask", {30'h0, r.c[4], r.c[3]}, w32(b + 8'h3));
    cmp("x", ok * r.x, w32(b + n - 8'hA));
    cmp("y", ok * r.y, w32(b + n - 8'h6));
    cmp("lock", r.lock, rx_u.dec[b + n - 8'h2]);
    cmp("close", 32'h7F, rx_u.dec[b + n - 8'h1]);
    if (r.c[3]) cmp("secs", 32'h0, w32(b + 8'h7));
    if (r.c[3]) cmp("ms", 32'h1, (w32(b + 8'hB) >> 16) < 32'd1000);
    else cmp("escapes", r.e, rx_u.ne);
    if (!r.st) cmp("period", 32'd40, t);
  endtask
  initial begin
    #30000;
    num_errors++;
    close_out();
  end
  initial begin
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    foreach (regs[i]) begin
      apb(1'b0, regs[i][39:32], 32'h0);
      cmp("reg", regs[i][31:0], rd);
      cmp("slverr", {31'h0, i == 4}, err);
    end
    apb(1'b1, PERIOD_OFS, 32'hA);
    apb(1'b0, PERIOD_OFS, 32'h0);
    cmp("period reg", 32'hA, rd);
    $display("register test done");
    foreach (rows[i]) begin
      @(posedge clk);
      link_open <= rows[i].lk;
      lock <= rows[i].lock;
      px <= rows[i].x;
      py <= rows[i].y;
      stall <= rows[i].st;
      apb(1'b1, CTRL_OFS, {27'h0, rows[i].c});
      repeat (3) wait_pk();
      if (!rows[i].pk) cmp("no packet", 32'd300, t);
      else chk(rows[i]);
      $display("row %0d done", i);
    end
    // Clock enable low freezes the period
    ce <= 1'b0;
    wait_pk();
    cmp("frozen", 32'd300, t);
    ce <= 1'b1;
    $display("freeze test done");
    // Stuffing off passes content raw
    @(posedge clk);
    px <= 32'h0000007E;
    apb(1'b1, CTRL_OFS, 32'h15);
    repeat (3) wait_pk();
    cmp("raw escapes", 32'h0, rx_u.ne);
    $display("raw test done");
    // Mid-run reset restores defaults
    @(posedge clk);
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    cmp("tx_valid", 32'h0, tx_valid);
    apb(1'b0, CTRL_OFS, 32'h0);
    cmp("ctrl after reset", 32'h13, rd);
    apb(1'b0, PERIOD_OFS, 32'h0);
    cmp("period after reset", 32'd100, rd);
    $display("reset test done");
    close_out();
  end
endmodule // test_position_packet_framer
`default_nettype wire
